// *** lcsp_pkg.sv ***
package lcsp_pkg;
	localparam int NUM_CH = 14;
	localparam int ALARM_W = 7;
	localparam int CABLE_W = 6;
	localparam int SEG_W = 7;
	localparam int SEG_TOP = 4;
	localparam int PTR_W = 6;
	localparam logic [PTR_W-1:0] FIFO_NEAR = 6'h03;
	localparam logic [3:0] OFF_IRQ_EN = 4'h4;
	localparam logic [3:0] OFF_STATUS = 4'h5;
	localparam logic [3:0] OFF_CHANGE = 4'h6;
	localparam logic [3:0] OFF_FIFO_CABLE = 4'h7;
	localparam logic [3:0] OFF_SEG1 = 4'h8;
	localparam logic [3:0] OFF_SEG2 = 4'h9;
	localparam logic [3:0] OFF_SEG3 = 4'ha;
	localparam logic [3:0] OFF_SEG4 = 4'hb;
	localparam logic [3:0] GLOBAL_PAGE = 4'he;
	localparam logic [3:0] OFF_GLOBAL = 4'h0;
	localparam int GIE_BIT = 1;
	localparam int FLS_BIT = 5;
	localparam int SEG_SIGN_BIT = 6;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [SEG_W-1:0] RST_SEG = 7'h00;
	localparam logic [CABLE_W-1:0] RST_CABLE = 6'h00;
	localparam logic RST_SOURCE = 1'b0;
	typedef enum logic [0:0] {
		LCSP_IDLE = 1'b0,
		LCSP_ACK  = 1'b1
	} lcsp_bus_state_t;
endpackage

// *** lcsp_fls_if.sv ***
`timescale 1ns/1ps
interface lcsp_fls_if;
	logic [lcsp_pkg::PTR_W-1:0] rx_wr_ptr;
	logic [lcsp_pkg::PTR_W-1:0] rx_rd_ptr;
	logic [lcsp_pkg::PTR_W-1:0] tx_wr_ptr;
	logic [lcsp_pkg::PTR_W-1:0] tx_rd_ptr;
	logic                       flag;
	logic                       source;
	modport hub (
		output rx_wr_ptr, rx_rd_ptr, tx_wr_ptr, tx_rd_ptr,
		input  flag, source
	);
	modport det (
		input  rx_wr_ptr, rx_rd_ptr, tx_wr_ptr, tx_rd_ptr,
		output flag, source
	);
endinterface

// *** lcsp_fifo_limit.sv ***
`timescale 1ns/1ps
module lcsp_fifo_limit (
	input  wire logic clk_i,
	input  wire logic rst_i,
	lcsp_fls_if.det   fls
);
	logic rx_near;
	logic tx_near;

	// Distance taken both ways round the ring, so wrap needs no special case
	function automatic logic ptr_near(input logic [lcsp_pkg::PTR_W-1:0] wr,
		input logic [lcsp_pkg::PTR_W-1:0] rd);
		logic [lcsp_pkg::PTR_W-1:0] fwd;
		logic [lcsp_pkg::PTR_W-1:0] back;
		fwd = wr - rd;
		back = rd - wr;
		ptr_near = (fwd <= lcsp_pkg::FIFO_NEAR) || (back <= lcsp_pkg::FIFO_NEAR);
	endfunction

	assign rx_near = ptr_near(fls.rx_wr_ptr, fls.rx_rd_ptr);
	assign tx_near = ptr_near(fls.tx_wr_ptr, fls.tx_rd_ptr);
	assign fls.flag = rx_near | tx_near;

	// Holds the last culprit while neither FIFO is at its limit; transmit wins when both are
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fls.source <= lcsp_pkg::RST_SOURCE;
		end else if (tx_near) begin
			fls.source <= 1'b1;
		end else if (rx_near) begin
			fls.source <= 1'b0;
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	tx_source_a: assert property (tx_near |=> fls.source)
		else $error("tx limit did not select transmit source");
	rx_source_a: assert property (rx_near && !tx_near |=> !fls.source)
		else $error("rx limit did not select receive source");
	source_hold_a: assert property (!fls.flag |=> $stable(fls.source))
		else $error("source changed with no limit");
	both_cv: cover property (rx_near && tx_near ##1 fls.source);
endmodule

// *** lcsp_regs.sv ***
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
// What this block does
// - Status change raises interrupt when enabled per channel and globally
// - Reading a status-change register clears it; bits that change in the read cycle stay set
// - FIFO source bit: 0 receive limit, 1 transmit limit, 1 when both
// - FIFO source bit is read-only and resets to 0
// - Cable loss is read-only 6-bit unsigned in bits 5..0, resets 0
// - Transmit pulse built from eight segment registers per channel
// - Segment one sets overshoot; one to four form the top portion
// - Segment five sets undershoot, held in the neighbouring slice
// - Segment value is 7-bit sign-magnitude, bit 6 set means positive
// - Segment one is read-write and resets to zero
// - Segments two to four are read-write 7-bit, like segment one
// - Segment register bit 7 reads zero and ignores writes
// - Interrupt output stays low while global enable is clear
// - FIFO limit alarm when pointers come within three bits
module lcsp_regs (
	input  wire logic                                      clk_i,
	input  wire logic                                      rst_i,
	input  wire logic                                      wb_cyc_i,
	input  wire logic                                      wb_stb_i,
	input  wire logic                                      wb_we_i,
	input  wire logic [9:0]                                wb_adr_i,
	input  wire logic [3:0]                                wb_sel_i,
	input  wire logic [31:0]                               wb_dat_i,
	output logic      [31:0]                               wb_dat_o,
	output logic                                           wb_ack_o,
	output logic                                           irq_o,
	output logic      [7:0]                                global_ctrl_o,
	input  wire logic [lcsp_pkg::NUM_CH*lcsp_pkg::ALARM_W-1:0] alarm_i,
	input  wire logic [lcsp_pkg::NUM_CH*lcsp_pkg::CABLE_W-1:0] cable_loss_i,
	input  wire logic [lcsp_pkg::NUM_CH*lcsp_pkg::PTR_W-1:0]   rx_wr_ptr_i,
	input  wire logic [lcsp_pkg::NUM_CH*lcsp_pkg::PTR_W-1:0]   rx_rd_ptr_i,
	input  wire logic [lcsp_pkg::NUM_CH*lcsp_pkg::PTR_W-1:0]   tx_wr_ptr_i,
	input  wire logic [lcsp_pkg::NUM_CH*lcsp_pkg::PTR_W-1:0]   tx_rd_ptr_i,
	output logic [lcsp_pkg::NUM_CH*lcsp_pkg::SEG_TOP*lcsp_pkg::SEG_W-1:0] seg_top_o
);
	localparam int NCH = lcsp_pkg::NUM_CH;
	localparam int SW = lcsp_pkg::SEG_W;

	lcsp_pkg::lcsp_bus_state_t state;
	lcsp_pkg::lcsp_bus_state_t next_state;
	logic       req;
	logic       wr_stb;
	logic       rd_stb;
	logic [3:0] page;
	logic [3:0] off;
	logic [7:0] wbyte;
	logic [7:0] next_rdata;
	logic [7:0] global_ctrl;
	logic       global_irq_enable;

	logic [7:0]                     irq_en [NCH];
	logic [7:0]                     live [NCH];
	logic [7:0]                     prev_status [NCH];
	logic [7:0]                     change [NCH];
	logic [7:0]                     change_set [NCH];
	logic [lcsp_pkg::CABLE_W-1:0]   cable [NCH];
	logic [SW-1:0]                  seg [NCH][lcsp_pkg::SEG_TOP];
	logic [NCH-1:0]                 irq_req;
	logic [NCH-1:0]                 fls_source;

	lcsp_fls_if fls_if [NCH] ();

	// Pages 0x0..0xd are channels; 0xe holds the global byte
	function automatic logic is_chan_page(input logic [3:0] p);
		is_chan_page = (p < 4'(NCH));
	endfunction

	function automatic logic is_seg_off(input logic [3:0] o);
		is_seg_off = (o >= lcsp_pkg::OFF_SEG1) && (o <= lcsp_pkg::OFF_SEG4);
	endfunction

	assign page = wb_adr_i[9:6];
	assign off = wb_adr_i[5:2];
	assign wbyte = wb_dat_i[7:0];
	assign req = wb_cyc_i && wb_stb_i && (state == lcsp_pkg::LCSP_IDLE);
	// Only lane 0 carries register data; upper lanes are ignored
	assign wr_stb = req && wb_we_i && wb_sel_i[0];
	assign rd_stb = req && !wb_we_i;
	assign wb_ack_o = (state == lcsp_pkg::LCSP_ACK);

	always_comb begin
		case (state)
			lcsp_pkg::LCSP_IDLE: begin
				next_state = req ? lcsp_pkg::LCSP_ACK : lcsp_pkg::LCSP_IDLE;
			end
			lcsp_pkg::LCSP_ACK: begin
				next_state = lcsp_pkg::LCSP_IDLE;
			end
			default: begin
				next_state = lcsp_pkg::LCSP_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= lcsp_pkg::LCSP_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			global_ctrl <= lcsp_pkg::RST_BYTE;
		end else if (wr_stb && page == lcsp_pkg::GLOBAL_PAGE && off == lcsp_pkg::OFF_GLOBAL) begin
			global_ctrl <= wbyte;
		end
	end

	assign global_ctrl_o = global_ctrl;
	assign global_irq_enable = global_ctrl[lcsp_pkg::GIE_BIT];
	// Level output, dropped as soon as the change register is read
	assign irq_o = global_irq_enable && (|irq_req);

	genvar g;
	genvar k;
	generate
		for (g = 0; g < NCH; g++) begin : ch
			logic sel;
			logic ch_wr;
			logic ch_rd;
			assign sel = (page == 4'(g));
			assign ch_wr = wr_stb && sel;
			assign ch_rd = rd_stb && sel;

			assign fls_if[g].rx_wr_ptr = rx_wr_ptr_i[g*lcsp_pkg::PTR_W +: lcsp_pkg::PTR_W];
			assign fls_if[g].rx_rd_ptr = rx_rd_ptr_i[g*lcsp_pkg::PTR_W +: lcsp_pkg::PTR_W];
			assign fls_if[g].tx_wr_ptr = tx_wr_ptr_i[g*lcsp_pkg::PTR_W +: lcsp_pkg::PTR_W];
			assign fls_if[g].tx_rd_ptr = tx_rd_ptr_i[g*lcsp_pkg::PTR_W +: lcsp_pkg::PTR_W];
			assign fls_source[g] = fls_if[g].source;

			lcsp_fifo_limit u_fls (
				.clk_i (clk_i),
				.rst_i (rst_i),
				.fls   (fls_if[g].det)
			);

			// Limit flag slots in at bit 5 between the external alarms
			assign live[g] = {alarm_i[g*lcsp_pkg::ALARM_W+5 +: 2], fls_if[g].flag,
				alarm_i[g*lcsp_pkg::ALARM_W +: 5]};
			assign change_set[g] = live[g] ^ prev_status[g];
			assign irq_req[g] = |(change[g] & irq_en[g]);

			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					irq_en[g] <= lcsp_pkg::RST_BYTE;
				end else if (ch_wr && off == lcsp_pkg::OFF_IRQ_EN) begin
					irq_en[g] <= wbyte;
				end
			end

			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					prev_status[g] <= lcsp_pkg::RST_BYTE;
				end else begin
					prev_status[g] <= live[g];
				end
			end

			// A change in the read cycle survives the clear: set wins
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					change[g] <= lcsp_pkg::RST_BYTE;
				end else if (ch_rd && off == lcsp_pkg::OFF_CHANGE) begin
					change[g] <= change_set[g];
				end else begin
					change[g] <= change[g] | change_set[g];
				end
			end

			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					cable[g] <= lcsp_pkg::RST_CABLE;
				end else begin
					cable[g] <= cable_loss_i[g*lcsp_pkg::CABLE_W +: lcsp_pkg::CABLE_W];
				end
			end

			for (k = 0; k < lcsp_pkg::SEG_TOP; k++) begin : sg
				// Bit 7 is never stored, so it cannot be written
				always_ff @(posedge clk_i) begin
					if (rst_i) begin
						seg[g][k] <= lcsp_pkg::RST_SEG;
					end else if (ch_wr && off == lcsp_pkg::OFF_SEG1 + 4'(k)) begin
						seg[g][k] <= wbyte[SW-1:0];
					end
				end
				// Slot 0 is the overshoot, slots 0..3 the top of the pulse;
				// the lower half, led by the undershoot, comes from the next slice
				assign seg_top_o[(g*lcsp_pkg::SEG_TOP+k)*SW +: SW] = seg[g][k];
			end
		end
	endgenerate

	always_comb begin
		next_rdata = lcsp_pkg::RST_BYTE;
		if (is_chan_page(page)) begin
			case (off)
				lcsp_pkg::OFF_IRQ_EN: begin
					next_rdata = irq_en[page];
				end
				lcsp_pkg::OFF_STATUS: begin
					next_rdata = live[page];
				end
				lcsp_pkg::OFF_CHANGE: begin
					next_rdata = change[page];
				end
				lcsp_pkg::OFF_FIFO_CABLE: begin
					next_rdata = {1'b0, fls_source[page], cable[page]};
				end
				lcsp_pkg::OFF_SEG1, lcsp_pkg::OFF_SEG2, lcsp_pkg::OFF_SEG3, lcsp_pkg::OFF_SEG4: begin
					next_rdata = {1'b0, seg[page][off[1:0]]};
				end
				default: begin
					next_rdata = lcsp_pkg::RST_BYTE;
				end
			endcase
		end else if (page == lcsp_pkg::GLOBAL_PAGE && off == lcsp_pkg::OFF_GLOBAL) begin
			next_rdata = global_ctrl;
		end
	end

	// Captured in the request cycle, the same edge that clears on read
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (rd_stb) begin
			wb_dat_o <= {24'h00_0000, next_rdata};
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	irq_gate_a: assert property (!global_irq_enable |-> !irq_o)
		else $error("interrupt high with global enable clear");
	irq_raise_a: assert property (global_irq_enable && (|irq_req) |-> irq_o)
		else $error("enabled change did not raise interrupt");
	change_irq_a: assert property (global_irq_enable && (|(change_set[0] & irq_en[0])) |=> irq_o)
		else $error("status change on channel 0 missed interrupt");
	read_clear_a: assert property (rd_stb && page == 4'h0 && off == lcsp_pkg::OFF_CHANGE
		&& change_set[0] == 8'h00 |=> change[0] == 8'h00)
		else $error("change register not cleared by read");
	seg_write_a: assert property (wr_stb && page == 4'h1 && off == lcsp_pkg::OFF_SEG2
		|=> seg[1][1] == $past(wbyte[6:0]))
		else $error("segment two write not stored");
	seg_msb_a: assert property (rd_stb && is_seg_off(off) && is_chan_page(page)
		|=> wb_ack_o && wb_dat_o[7] == 1'b0)
		else $error("segment bit 7 read nonzero");
	seg_reset_a: assert property ($fell(rst_i) |-> seg[0][0] == 7'h00 && seg[13][3] == 7'h00)
		else $error("segment not zero after reset");
	cable_read_a: assert property (rd_stb && page == 4'h2 && off == lcsp_pkg::OFF_FIFO_CABLE
		|=> wb_dat_o[5:0] == $past(cable[2]) && wb_dat_o[7] == 1'b0)
		else $error("cable loss read wrong");
	page_sel_a: assert property (wr_stb && page == 4'h3 && off == lcsp_pkg::OFF_SEG1
		|=> $stable(seg[4][0]))
		else $error("write leaked into another channel");
	ack_pulse_a: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single cycle");

	// Bus handshake and read data
	ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held past one cycle");
	ack_no_req_a: assert property (!(wb_cyc_i && wb_stb_i)
		|=> !wb_ack_o)
		else $error("ack without a request");
	rdata_upper_a: assert property (wb_ack_o
		|-> wb_dat_o[31:8] == 24'h00_0000)
		else $error("upper read lanes not zero");
	rdata_hold_a: assert property (!rd_stb
		|=> $stable(wb_dat_o))
		else $error("read data changed without a read");
	unmapped_page_a: assert property (rd_stb && page == 4'hf
		|=> wb_dat_o == 32'h0000_0000)
		else $error("unmapped page read nonzero");
	sel_drop_a: assert property (req && wb_we_i && !wb_sel_i[0]
		|=> $stable(seg[3][0]) && $stable(irq_en[3]) && $stable(global_ctrl_o))
		else $error("write with lane 0 off was stored");
	read_no_write_a: assert property (rd_stb
		|=> $stable(global_ctrl_o) && $stable(seg[0][3]))
		else $error("read altered a register");
	reset_out_a: assert property ($fell(rst_i)
		|-> !irq_o && !wb_ack_o && wb_dat_o == 32'h0000_0000)
		else $error("outputs not idle after reset");

	// Interrupt enables and change bits
	irq_en_write_a: assert property (wr_stb && page == 4'h1 && off == lcsp_pkg::OFF_IRQ_EN
		|=> irq_en[1] == $past(wbyte))
		else $error("interrupt enable write not stored");
	change_set_a: assert property (change_set[1] != 8'h00
		|=> (change[1] & $past(change_set[1])) == $past(change_set[1]))
		else $error("status change not latched");
	change_keep_a: assert property (!(rd_stb && page == 4'h1 && off == lcsp_pkg::OFF_CHANGE)
		|=> (change[1] & $past(change[1])) == $past(change[1]))
		else $error("change bit lost without a read");
	clear_other_a: assert property (rd_stb && page == 4'h5 && off == lcsp_pkg::OFF_CHANGE
		|=> change[5] == $past(change_set[5]))
		else $error("channel 5 change not cleared by read");
	change_read_a: assert property (rd_stb && page == 4'h1 && off == lcsp_pkg::OFF_CHANGE
		|=> wb_dat_o[7:0] == $past(change[1]))
		else $error("change read returned wrong value");
	global_write_a: assert property (wr_stb && page == lcsp_pkg::GLOBAL_PAGE
		&& off == lcsp_pkg::OFF_GLOBAL |=> global_ctrl_o == $past(wbyte))
		else $error("global byte write not stored");
	global_keep_a: assert property (!(wr_stb && page == lcsp_pkg::GLOBAL_PAGE
		&& off == lcsp_pkg::OFF_GLOBAL) |=> $stable(global_ctrl_o))
		else $error("global byte changed without its write");

	// Channels 0, 2, 5, 6 and 9 stand for all; every channel is one generated copy
	status_read_a: assert property (rd_stb && page == 4'h2 && off == lcsp_pkg::OFF_STATUS
		|=> wb_dat_o[7:0] == $past(live[2]))
		else $error("status read returned wrong value");
	near_equal_a: assert property (rx_wr_ptr_i[5:0] == rx_rd_ptr_i[5:0]
		|-> live[0][lcsp_pkg::FLS_BIT])
		else $error("equal pointers gave no limit flag");
	far_clear_a: assert property ((rx_wr_ptr_i[5:0] - rx_rd_ptr_i[5:0]) == 6'h20
		&& (tx_wr_ptr_i[5:0] - tx_rd_ptr_i[5:0]) == 6'h20 |-> !live[0][lcsp_pkg::FLS_BIT])
		else $error("limit flag with pointers half a ring apart");
	source_read_a: assert property (rd_stb && page == 4'h2 && off == lcsp_pkg::OFF_FIFO_CABLE
		|=> wb_dat_o[6] == $past(fls_source[2]))
		else $error("fifo source read wrong");
	cable_track_a: assert property (1'b1 |=> cable[6] == $past(cable_loss_i[41:36]))
		else $error("cable loss not tracking its input");
	seg_sign_a: assert property (wr_stb && page == 4'h0 && off == lcsp_pkg::OFF_SEG1
		|=> seg[0][0][lcsp_pkg::SEG_SIGN_BIT] == $past(wbyte[lcsp_pkg::SEG_SIGN_BIT]))
		else $error("segment sign bit not stored");
	seg_four_a: assert property (wr_stb && page == 4'h9 && off == lcsp_pkg::OFF_SEG4
		|=> seg[9][3] == $past(wbyte[6:0]))
		else $error("segment four write not stored");
	seg_hold_a: assert property (!(wr_stb && page == 4'h5)
		|=> $stable(seg[5][2]))
		else $error("segment changed without a write");

	irq_cv: cover property (global_irq_enable && !irq_o ##1 irq_o);
	clr_cv: cover property (irq_o && rd_stb && off == lcsp_pkg::OFF_CHANGE ##1 !irq_o);
	seg_cv: cover property (wr_stb && is_seg_off(off) && wbyte[lcsp_pkg::SEG_SIGN_BIT]);
	glob_cv: cover property (wr_stb && page == lcsp_pkg::GLOBAL_PAGE);
endmodule

// *** lcsp_host_model.sv ***
`timescale 1ns/1ps
module lcsp_host_model (
	input  wire logic        clk_i,
	output logic             cyc_o,
	output logic             stb_o,
	output logic             we_o,
	output logic [9:0]       adr_o,
	output logic [3:0]       sel_o,
	output logic [31:0]      dat_o,
	input  wire logic [31:0] dat_i,
	input  wire logic        ack_i
);
	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o = 1'b0;
		adr_o = 10'h000;
		sel_o = 4'h0;
		dat_o = 32'h00000000;
	end
	// Released address and data lines are inverted so stale values never pass for live ones
	task automatic xfer(input logic we, input logic [9:0] adr, input logic [7:0] d, output logic [31:0] q);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= we;
		adr_o <= adr;
		sel_o <= 4'h1;
		dat_o <= {24'h000000, d};
		do @(posedge clk_i); while (ack_i !== 1'b1);
		q = dat_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		we_o <= 1'b0;
		sel_o <= 4'h0;
		adr_o <= ~adr;
		dat_o <= ~{24'h000000, d};
	endtask
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
	logic        clk_i;
	logic        rst_i;
	logic        wb_cyc;
	logic        wb_stb;
	logic        wb_we;
	logic [9:0]  wb_adr;
	logic [3:0]  wb_sel;
	logic [31:0] wb_wdat;
	logic [31:0] wb_rdat;
	logic        wb_ack;
	logic        irq;
	logic [7:0]  gctrl;
	logic [97:0] alarm;
	logic [83:0] cable;
	logic [83:0] rx_wr;
	logic [83:0] rx_rd;
	logic [83:0] tx_wr;
	logic [83:0] tx_rd;
	logic [391:0] seg_top;
	logic [31:0] q;
	int          n_errors;
	int          comparisons;
	int          cycles;
	lcsp_host_model host (.clk_i(clk_i), .cyc_o(wb_cyc), .stb_o(wb_stb), .we_o(wb_we), .adr_o(wb_adr),
		.sel_o(wb_sel), .dat_o(wb_wdat), .dat_i(wb_rdat), .ack_i(wb_ack));
	lcsp_regs dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
		.irq_o(irq), .global_ctrl_o(gctrl), .alarm_i(alarm), .cable_loss_i(cable), .rx_wr_ptr_i(rx_wr),
		.rx_rd_ptr_i(rx_rd), .tx_wr_ptr_i(tx_wr), .tx_rd_ptr_i(tx_rd), .seg_top_o(seg_top));
	always #50 clk_i = ~clk_i;
	task automatic summarize();
		if (n_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		// Whole run needs under two hundred cycles
		if (cycles == 20000) begin
			n_errors++;
			summarize();
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] c, input logic [3:0] off, input logic [7:0] d);
		host.xfer(1'b1, {c, off, 2'b00}, d, q);
	endtask
	task automatic rd(input logic [3:0] c, input logic [3:0] off);
		host.xfer(1'b0, {c, off, 2'b00}, 8'h00, q);
	endtask
	task automatic t_reset();
		rd(4'h0, 4'h7);
		chk("fifo_cable_rst", q, 32'h00000000);
		for (int k = 8; k < 12; k++) begin
			rd(4'hd, k[3:0]);
			chk("seg_rst", q, 32'h00000000);
		end
		@(negedge clk_i);
		chk("irq_rst", {31'h0, irq}, 32'h00000000);
	endtask
	task automatic t_segments();
		logic [7:0] v [4] = '{8'hff, 8'hc5, 8'h3a, 8'h80};
		for (int k = 0; k < 4; k++) wr(4'h3, 4'h8 + k[3:0], v[k]);
		for (int k = 0; k < 4; k++) begin
			rd(4'h3, 4'h8 + k[3:0]);
			chk("seg_read", q, {25'h0, v[k][6:0]});
			chk("seg_out", {25'h0, seg_top[(3*4+k)*7 +: 7]}, {25'h0, v[k][6:0]});
			rd(4'h4, 4'h8 + k[3:0]);
			chk("seg_other_ch", q, 32'h00000000);
		end
		wr(4'h0, 4'hc, 8'h55);
		rd(4'h0, 4'hc);
		chk("unmapped", q, 32'h00000000);
	endtask
	task automatic t_cable();
		@(posedge clk_i);
		cable[5*6 +: 6] <= 6'h2a;
		wr(4'h5, 4'h7, 8'hff);
		rd(4'h5, 4'h7);
		chk("cable_loss", q, 32'h0000002a);
	endtask
	task automatic fifo_step(input logic [5:0] rxw, input logic [5:0] txw, input logic [7:0] st, input logic [7:0] fc);
		@(posedge clk_i);
		rx_wr[2*6 +: 6] <= rxw;
		tx_wr[2*6 +: 6] <= txw;
		repeat (2) @(posedge clk_i);
		rd(4'h2, 4'h5);
		chk("fifo_flag", q, {24'h0, st});
		rd(4'h2, 4'h7);
		chk("fifo_source", q, {24'h0, fc});
	endtask
	task automatic t_fifo();
		fifo_step(6'h03, 6'h20, 8'h20, 8'h00);
		fifo_step(6'h04, 6'h3d, 8'h20, 8'h40);
		fifo_step(6'h04, 6'h20, 8'h00, 8'h40);
		fifo_step(6'h3d, 6'h03, 8'h20, 8'h40);
		fifo_step(6'h3d, 6'h20, 8'h20, 8'h00);
	endtask
	task automatic t_irq();
		wr(4'h1, 4'h4, 8'h01);
		@(posedge clk_i);
		alarm[1*7] <= 1'b1;
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		chk("irq_gie_off", {31'h0, irq}, 32'h00000000);
		wr(4'he, 4'h0, 8'h02);
		@(negedge clk_i);
		chk("global_ctrl", {24'h0, gctrl}, 32'h00000002);
		chk("irq_on", {31'h0, irq}, 32'h00000001);
		rd(4'h1, 4'h6);
		chk("change_read", q, 32'h00000001);
		@(negedge clk_i);
		chk("irq_cleared", {31'h0, irq}, 32'h00000000);
		rd(4'h1, 4'h6);
		chk("change_empty", q, 32'h00000000);
		@(posedge clk_i);
		alarm[1*7+1] <= 1'b1;
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		chk("irq_masked", {31'h0, irq}, 32'h00000000);
	endtask
	initial begin
		clk_i = 1'b0;
		rst_i = 1'b1;
		n_errors = 0;
		comparisons = 0;
		cycles = 0;
		alarm = '0;
		cable = '0;
		// Pointers start far apart so no limit is seen out of reset
		rx_wr = {14{6'h20}};
		tx_wr = {14{6'h20}};
		rx_rd = '0;
		tx_rd = '0;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_segments();
		t_cable();
		t_fifo();
		t_irq();
		summarize();
	end
endmodule
